// ---- uwb_baud_gen.sv ----
// fractional bit-rate tick generator by phase accumulation
`include "uwb_params.svh"
module uwb_baud_gen #(
  parameter int unsigned W = 21,
  parameter logic [20:0] MODULUS = 21'(`UWB_DIV_DEN)
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [W-1:0] inc,
  output logic tick
);

  logic [W-1:0] acc_q;
  logic [W:0] sum;
  logic wrap;

  assign sum = {1'b0, acc_q} + {1'b0, inc};
  assign wrap = sum >= {1'b0, MODULUS};
  // one tick per modulus worth of divisor; long-run rate is exact
  assign tick = wrap;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      acc_q <= '0;
    else if (wrap)
      acc_q <= W'(sum - {1'b0, MODULUS}); // RULE_03
    else
      acc_q <= W'(sum);
  end

endmodule

// ---- uwb_host_model.sv ----
// far-end serial device: frames bytes to and from the port
module uwb_host_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic txd,
  output logic rxd,
  output logic cts_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int bit_clk = 20;
  logic drv_q = 1'b1;
  logic cts_q = 1'b0;
  // line left to its pull-up outside frames and while the port is reset
  assign rxd = nrst ? drv_q : 1'b1;
  assign cts_n = cts_q;
  task automatic bits(input logic b, input int n);
    drv_q <= b;
    repeat (n) @(posedge core_clk);
  endtask
  task automatic send(input logic [7:0] d, input logic [1:0] par,
    input logic two, input logic bad_par, input logic bad_stop);
    @(posedge core_clk);
    bits(1'b0, bit_clk);
    for (int i = 0; i < 8; i++)
      bits(d[i], bit_clk);
    if (par != 2'b00)
      bits(((par == 2'b01) ? ~^d : ^d) ^ bad_par, bit_clk);
    bits(!bad_stop, two ? 2 * bit_clk : bit_clk);
    bits(1'b1, bit_clk);
  endtask
  task automatic take(input logic par_on, output logic [7:0] d,
    output logic p, output logic s);
    int n;
    n = 0;
    p = 1'b0;
    while (txd !== 1'b0 && n < 5000)
    begin
      @(negedge core_clk);
      n++;
    end
    repeat (bit_clk / 2) @(negedge core_clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (bit_clk) @(negedge core_clk);
      d[i] = txd;
    end
    if (par_on)
    begin
      repeat (bit_clk) @(negedge core_clk);
      p = txd;
    end
    repeat (bit_clk) @(negedge core_clk);
    s = txd;
  endtask
endmodule

// ---- uwb_params.svh ----
// constants for the serial port with break reset
// Summary of operation
// RULE_01 - The port has one serial input, one serial output and optional active-low request/clear-to-send lines.
// RULE_02 - Characters carry 8 data bits with parity none, odd or even, one or two stop bits, and optional flow control.
// RULE_03 - The bit rate equals the stored divisor divided by 0.004096, covering 1200 bps to 3 Mbps.
// RULE_04 - Divisors 0x0027, 0x01D8 and 0x2C3D give 9600, 115200 and 2764800 bps within small error.
// RULE_05 - A continuous low on the serial input longer than the timeout in microseconds resets the device.
// RULE_06 - A timeout below 1000 counts as zero and one above 255000 is clamped to 255000.
// RULE_07 - The device can hold its serial output low to send a break that wakes the host.
// RULE_08 - All serial outputs float while the device is held in reset.
// RULE_09 - Any other driver on the shared lines releases them once the device leaves reset.
// RULE_10 - A character is a low start bit, data LSB first, optional parity, then high stop bits on an idle-high line.
`ifndef UWB_PARAMS_SVH
`define UWB_PARAMS_SVH

`define UWB_CLK_HZ 50000000
`define UWB_CLK_MHZ 50
// rate = divisor * 1e6 / 4096, so bit period in clocks = CLK_MHZ*4096/div
`define UWB_DIV_DEN (`UWB_CLK_MHZ * 4096)
`define UWB_OVERSAMPLE 16
`define UWB_US_TIME_NS 1000
`define UWB_US_CYC ((`UWB_US_TIME_NS * `UWB_CLK_MHZ) / 1000)
`define UWB_TO_MIN 18'd1000
`define UWB_TO_MAX 18'd255000

`define UWB_ADDR_CTRL 8'h00
`define UWB_ADDR_DIV 8'h04
`define UWB_ADDR_BRKTO 8'h08
`define UWB_ADDR_TXDATA 8'h0c
`define UWB_ADDR_RXDATA 8'h10
`define UWB_ADDR_STATUS 8'h14
`define UWB_ADDR_IRQ_STAT 8'h18
`define UWB_ADDR_IRQ_MASK 8'h1c

`define UWB_CTRL_RST 5'h00
`define UWB_DIV_RST 16'h01d8
`define UWB_BRKTO_RST 18'h00000

`define UWB_IRQ_RX_DONE 0
`define UWB_IRQ_TX_DONE 1
`define UWB_IRQ_PAR_ERR 2
`define UWB_IRQ_FRM_ERR 3
`define UWB_IRQ_BREAK 4
`define UWB_IRQ_W 5

`endif

// ---- uwb_pkg.sv ----
// types shared by the serial port files
package uwb_pkg;

  typedef enum logic [1:0] {
    UWB_PAR_NONE = 2'b00,
    UWB_PAR_ODD = 2'b01,
    UWB_PAR_EVEN = 2'b10
  } uwb_parity_t;

  typedef struct packed {
    logic tx_break;
    logic flow_en;
    logic two_stop;
    uwb_parity_t parity;
  } uwb_cfg_t;

  typedef enum logic [2:0] {
    UWB_TX_IDLE = 3'b000,
    UWB_TX_START = 3'b001,
    UWB_TX_DATA = 3'b010,
    UWB_TX_PAR = 3'b011,
    UWB_TX_STOP1 = 3'b100,
    UWB_TX_STOP2 = 3'b101,
    UWB_TX_BRK = 3'b110
  } uwb_tx_state_t;

  typedef enum logic [2:0] {
    UWB_RX_IDLE = 3'b000,
    UWB_RX_START = 3'b001,
    UWB_RX_DATA = 3'b010,
    UWB_RX_PAR = 3'b011,
    UWB_RX_STOP = 3'b100
  } uwb_rx_state_t;

  typedef struct packed {
    logic brk;
    logic frm_err;
    logic par_err;
    logic tx_done;
    logic rx_done;
  } uwb_irq_t;

endpackage

// ---- uwb_uart.sv ----
// serial port with flow control, break send and break-timeout reset
//
// Implementation choices: the plain strobed port and the placing of the registers.
`include "uwb_params.svh"
module uwb_uart (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic rxd_i,
  input wire logic cts_n_i,
  output logic txd_o,
  output logic txd_oe,
  output logic rts_n_o,
  output logic rts_n_oe,
  output logic irq,
  output logic break_reset_req
);

  // configuration registers
  uwb_pkg::uwb_cfg_t cfg_q;
  logic [15:0] div_q;
  logic [17:0] brkto_q;
  logic [`UWB_IRQ_W-1:0] irq_stat_q;
  logic [`UWB_IRQ_W-1:0] irq_mask_q;
  logic [31:0] rdata_q;

  // pin synchronisers: bit 0 rx, bit 1 cts
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic rx_s;
  logic cts_n_s;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      sync1_q <= 2'b11;
      sync2_q <= 2'b11;
    end
    else
    begin
      sync1_q <= {cts_n_i, rxd_i};
      sync2_q <= sync1_q;
    end
  end
  assign rx_s = sync2_q[0];
  assign cts_n_s = sync2_q[1];

  // register decode
  wire wr_ctrl = reg_wr && (reg_addr == `UWB_ADDR_CTRL);
  wire wr_div = reg_wr && (reg_addr == `UWB_ADDR_DIV);
  wire wr_brkto = reg_wr && (reg_addr == `UWB_ADDR_BRKTO);
  wire wr_tx = reg_wr && (reg_addr == `UWB_ADDR_TXDATA);
  wire wr_istat = reg_wr && (reg_addr == `UWB_ADDR_IRQ_STAT);
  wire wr_imask = reg_wr && (reg_addr == `UWB_ADDR_IRQ_MASK);
  wire rd_rx = reg_rd && (reg_addr == `UWB_ADDR_RXDATA);

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      cfg_q <= uwb_pkg::uwb_cfg_t'(`UWB_CTRL_RST);
      div_q <= `UWB_DIV_RST; // RULE_04
      brkto_q <= `UWB_BRKTO_RST;
      irq_mask_q <= '0;
    end
    else
    begin
      if (wr_ctrl)
        cfg_q <= uwb_pkg::uwb_cfg_t'(reg_wdata[4:0]); // RULE_02
      if (wr_div)
        div_q <= reg_wdata[15:0]; // RULE_03
      if (wr_brkto)
        brkto_q <= reg_wdata[17:0];
      if (wr_imask)
        irq_mask_q <= reg_wdata[`UWB_IRQ_W-1:0];
    end
  end

  // bit-rate ticks; rx runs at sixteen times the bit rate
  logic tx_tick;
  logic rx_tick;

  uwb_baud_gen u_tx_baud (
    .core_clk(core_clk),
    .nrst(nrst),
    .inc({5'h00, div_q}),
    .tick(tx_tick)
  );

  uwb_baud_gen u_rx_baud (
    .core_clk(core_clk),
    .nrst(nrst),
    .inc({1'b0, div_q, 4'h0}),
    .tick(rx_tick)
  );

  // transmitter
  uwb_pkg::uwb_tx_state_t tx_st_q;
  logic [7:0] tx_buf_q;
  logic tx_pend_q;
  logic [7:0] tx_sh_q;
  logic [2:0] tx_bit_q;
  logic tx_par_q;
  logic txd_q;
  logic tx_done_ev;

  wire par_on = cfg_q.parity != uwb_pkg::UWB_PAR_NONE;
  wire par_odd = cfg_q.parity == uwb_pkg::UWB_PAR_ODD;
  wire tx_clear = !cfg_q.flow_en || !cts_n_s; // RULE_01
  wire tx_go = tx_pend_q && tx_clear && !cfg_q.tx_break;
  wire tx_idle = tx_st_q == uwb_pkg::UWB_TX_IDLE;
  wire tx_take = tx_tick && tx_idle && tx_go;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      tx_buf_q <= 8'h00;
      tx_pend_q <= 1'b0;
    end
    else if (wr_tx && !tx_pend_q)
    begin
      tx_buf_q <= reg_wdata[7:0];
      tx_pend_q <= 1'b1;
    end
    else if (tx_take)
      tx_pend_q <= 1'b0;
  end

  assign tx_done_ev = tx_tick && ((tx_st_q == uwb_pkg::UWB_TX_STOP2) ||
    (tx_st_q == uwb_pkg::UWB_TX_STOP1 && !cfg_q.two_stop));

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      tx_st_q <= uwb_pkg::UWB_TX_IDLE;
      tx_sh_q <= 8'h00;
      tx_bit_q <= 3'h0;
      tx_par_q <= 1'b0;
      txd_q <= 1'b1;
    end
    else if (tx_tick)
    begin
      case (tx_st_q)
        uwb_pkg::UWB_TX_IDLE:
        begin
          if (cfg_q.tx_break)
          begin
            tx_st_q <= uwb_pkg::UWB_TX_BRK;
            txd_q <= 1'b0; // RULE_07
          end
          else if (tx_go)
          begin
            tx_st_q <= uwb_pkg::UWB_TX_START;
            tx_sh_q <= tx_buf_q;
            tx_par_q <= par_odd ? ~^tx_buf_q : ^tx_buf_q;
            tx_bit_q <= 3'h0;
            txd_q <= 1'b0; // RULE_10
          end
          else
            txd_q <= 1'b1;
        end
        uwb_pkg::UWB_TX_START:
        begin
          tx_st_q <= uwb_pkg::UWB_TX_DATA;
          txd_q <= tx_sh_q[0]; // RULE_10
          tx_sh_q <= {1'b0, tx_sh_q[7:1]};
        end
        uwb_pkg::UWB_TX_DATA:
        begin
          tx_bit_q <= tx_bit_q + 3'h1;
          if (tx_bit_q == 3'h7)
          begin
            tx_st_q <= par_on ? uwb_pkg::UWB_TX_PAR : uwb_pkg::UWB_TX_STOP1;
            txd_q <= par_on ? tx_par_q : 1'b1; // RULE_02
          end
          else
          begin
            txd_q <= tx_sh_q[0];
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
          end
        end
        uwb_pkg::UWB_TX_PAR:
        begin
          tx_st_q <= uwb_pkg::UWB_TX_STOP1;
          txd_q <= 1'b1;
        end
        uwb_pkg::UWB_TX_STOP1:
        begin
          tx_st_q <= cfg_q.two_stop ? uwb_pkg::UWB_TX_STOP2 :
            uwb_pkg::UWB_TX_IDLE; // RULE_02
          txd_q <= 1'b1;
        end
        uwb_pkg::UWB_TX_STOP2:
        begin
          tx_st_q <= uwb_pkg::UWB_TX_IDLE;
          txd_q <= 1'b1;
        end
        uwb_pkg::UWB_TX_BRK:
        begin
          // hold the line low for as long as software keeps the bit set
          if (!cfg_q.tx_break)
          begin
            tx_st_q <= uwb_pkg::UWB_TX_IDLE;
            txd_q <= 1'b1;
          end
        end
        default:
        begin
          tx_st_q <= uwb_pkg::UWB_TX_IDLE;
          txd_q <= 1'b1;
        end
      endcase
    end
  end

  // receiver, sampling mid-bit on the sixteen-times tick
  uwb_pkg::uwb_rx_state_t rx_st_q;
  logic [3:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic [7:0] rx_data_q;
  logic rx_valid_q;
  logic rx_perr_q;
  logic rx_done_ev;
  logic rx_frm_ev;

  wire rx_mid = rx_tick && (rx_cnt_q == 4'hf);
  wire rx_par_bad = par_odd ? (~^rx_sh_q != rx_s) : (^rx_sh_q != rx_s);
  assign rx_done_ev = rx_mid && (rx_st_q == uwb_pkg::UWB_RX_STOP);
  assign rx_frm_ev = rx_done_ev && !rx_s;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      rx_st_q <= uwb_pkg::UWB_RX_IDLE;
      rx_cnt_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_perr_q <= 1'b0;
    end
    else
    begin
      if (rx_tick)
        rx_cnt_q <= rx_cnt_q + 4'h1;
      case (rx_st_q)
        uwb_pkg::UWB_RX_IDLE:
        begin
          rx_cnt_q <= 4'h0;
          if (!rx_s)
            rx_st_q <= uwb_pkg::UWB_RX_START; // RULE_10
        end
        uwb_pkg::UWB_RX_START:
          if (rx_tick && rx_cnt_q == 4'h7)
          begin
            // a glitch shorter than half a bit is not a start bit
            rx_st_q <= rx_s ? uwb_pkg::UWB_RX_IDLE : uwb_pkg::UWB_RX_DATA;
            rx_cnt_q <= 4'h0;
            rx_bit_q <= 3'h0;
            rx_perr_q <= 1'b0;
          end
        uwb_pkg::UWB_RX_DATA:
          if (rx_mid)
          begin
            rx_sh_q <= {rx_s, rx_sh_q[7:1]}; // RULE_10
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == 3'h7)
              rx_st_q <= par_on ? uwb_pkg::UWB_RX_PAR : uwb_pkg::UWB_RX_STOP;
          end
        uwb_pkg::UWB_RX_PAR:
          if (rx_mid)
          begin
            rx_perr_q <= rx_par_bad; // RULE_02
            rx_st_q <= uwb_pkg::UWB_RX_STOP;
          end
        uwb_pkg::UWB_RX_STOP:
          if (rx_mid)
            rx_st_q <= uwb_pkg::UWB_RX_IDLE;
        default:
          rx_st_q <= uwb_pkg::UWB_RX_IDLE;
      endcase
    end
  end

  // received byte holding register; a new byte overwrites an unread one
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
    end
    else if (rx_done_ev)
    begin
      rx_data_q <= rx_sh_q;
      rx_valid_q <= 1'b1;
    end
    else if (rd_rx)
      rx_valid_q <= 1'b0;
  end

  // break timeout: count whole microseconds of unbroken low input
  logic [5:0] us_pre_q;
  logic [17:0] low_us_q;
  logic brk_fired_q;
  logic [17:0] to_eff;

  assign to_eff = (brkto_q < `UWB_TO_MIN) ? 18'h00000 :
    (brkto_q > `UWB_TO_MAX) ? `UWB_TO_MAX : brkto_q; // RULE_06
  wire us_tick = us_pre_q == 6'(`UWB_US_CYC - 1);
  wire brk_hit = !rx_s && !brk_fired_q && (to_eff != 18'h00000) &&
    (low_us_q > to_eff); // RULE_05

  always_ff @(posedge core_clk)
  begin
    if (!nrst || rx_s)
    begin
      us_pre_q <= 6'h00;
      low_us_q <= 18'h00000;
      brk_fired_q <= 1'b0;
    end
    else
    begin
      us_pre_q <= us_tick ? 6'h00 : us_pre_q + 6'h01;
      if (us_tick && low_us_q != 18'h3ffff)
        low_us_q <= low_us_q + 18'h00001; // RULE_05
      if (brk_hit)
        brk_fired_q <= 1'b1;
    end
  end
  assign break_reset_req = brk_hit; // RULE_05

  // interrupt status, write one to clear, a new event wins over the clear
  uwb_pkg::uwb_irq_t irq_ev;
  assign irq_ev.rx_done = rx_done_ev;
  assign irq_ev.tx_done = tx_done_ev;
  assign irq_ev.par_err = rx_done_ev && rx_perr_q;
  assign irq_ev.frm_err = rx_frm_ev;
  assign irq_ev.brk = brk_hit;
  wire [`UWB_IRQ_W-1:0] irq_clr = wr_istat ? reg_wdata[`UWB_IRQ_W-1:0] : '0;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      irq_stat_q <= '0;
    else
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // read data, answered the cycle after the strobe
  wire [31:0] status_w = {26'h0, cts_n_s, rx_s, cfg_q.tx_break && !tx_idle,
    rx_valid_q, !tx_idle, tx_pend_q};
  wire [31:0] rd_mux =
    (reg_addr == `UWB_ADDR_CTRL) ? {27'h0, cfg_q} :
    (reg_addr == `UWB_ADDR_DIV) ? {16'h0, div_q} :
    (reg_addr == `UWB_ADDR_BRKTO) ? {14'h0, brkto_q} :
    (reg_addr == `UWB_ADDR_TXDATA) ? {24'h0, tx_buf_q} :
    (reg_addr == `UWB_ADDR_RXDATA) ? {24'h0, rx_data_q} :
    (reg_addr == `UWB_ADDR_STATUS) ? status_w :
    (reg_addr == `UWB_ADDR_IRQ_STAT) ? {27'h0, irq_stat_q} :
    (reg_addr == `UWB_ADDR_IRQ_MASK) ? {27'h0, irq_mask_q} : 32'h0;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      rdata_q <= 32'h0;
    else
      rdata_q <= reg_rd ? rd_mux : 32'h0;
  end
  assign reg_rdata = rdata_q;

  // pin drivers float while reset is held
  logic rts_n_q;
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      rts_n_q <= 1'b1;
    else
      rts_n_q <= cfg_q.flow_en ? rx_valid_q : 1'b0; // RULE_01
  end
  assign txd_o = txd_q;
  assign rts_n_o = rts_n_q;
  assign txd_oe = nrst; // RULE_08
  assign rts_n_oe = nrst; // RULE_08

endmodule

// ---- uwb_uart_checker.sv ----
// assertions on the serial port pins and break reset request
`include "uwb_params.svh"
module uwb_uart_checker (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic rxd_i,
  input wire logic cts_n_i,
  input wire logic txd_o,
  input wire logic txd_oe,
  input wire logic rts_n_o,
  input wire logic rts_n_oe,
  input wire logic irq,
  input wire logic break_reset_req
);
  logic brk_q, flow_q, seen_q;
  logic [17:0] to_q;
  logic [31:0] low_q, eff, lim;
  // timeout as applied: small values switch it off, large ones clamp
  assign eff = (to_q < `UWB_TO_MIN) ? 32'h0 : (to_q > `UWB_TO_MAX) ?
    32'(`UWB_TO_MAX) : 32'(to_q);
  assign lim = eff * `UWB_US_CYC;
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      brk_q <= 1'b0;
      flow_q <= 1'b0;
      to_q <= 18'h0;
      low_q <= 32'h0;
      seen_q <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == `UWB_ADDR_CTRL)
      begin
        brk_q <= reg_wdata[4];
        flow_q <= reg_wdata[3];
      end
      if (reg_wr && reg_addr == `UWB_ADDR_BRKTO)
        to_q <= reg_wdata[17:0];
      low_q <= rxd_i ? 32'h0 : low_q + 32'h1;
      seen_q <= !rxd_i && (seen_q || break_reset_req);
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  a_oe_on: assert property (disable iff (1'b0)
    txd_oe == nrst && rts_n_oe == nrst)
    else $error("port enable wrong");
  a_idle_after_rst: assert property ($rose(nrst) |-> txd_o && rts_n_o)
    else $error("lines not idle");
  // no bit in the supported range is shorter than 16 clocks
  a_bit_len_min: assert property ($fell(txd_o) && !brk_q |->
    !txd_o [*8] ##1 !txd_o [*8])
    else $error("low bit too short");
  a_break_holds: assert property (brk_q && !txd_o |=> !txd_o)
    else $error("break released");
  a_flow_off_rts: assert property (!flow_q && !$past(flow_q) &&
    $past(nrst) && $past(nrst, 2) |-> !rts_n_o)
    else $error("rts high without flow");
  a_brk_not_early: assert property (break_reset_req |->
    eff != 32'h0 && low_q >= lim)
    else $error("break reset early");
  a_brk_once: assert property (break_reset_req |-> !seen_q)
    else $error("second break reset");
  a_brk_in_time: assert property (eff != 32'h0 &&
    low_q >= lim + 32'h100 |-> seen_q || break_reset_req)
    else $error("break reset late");
endmodule
bind uwb_uart uwb_uart_checker u_chk (.core_clk(core_clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd_i(rxd_i),
  .cts_n_i(cts_n_i), .txd_o(txd_o), .txd_oe(txd_oe), .rts_n_o(rts_n_o),
  .rts_n_oe(rts_n_oe), .irq(irq), .break_reset_req(break_reset_req));

// ---- uwb_uart_tb.sv ----
// bench for the serial port with break reset
`define UWB_CHK(a, b, m) \
  begin \
    check_count++; \
    if ((a) !== (b)) \
    begin \
      failures++; \
      $display("wrong value at %0t: %s", $time, m); \
    end \
  end
module uwb_uart_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, v;
  logic rxd, cts_n, txd_o, txd_oe, rts_n_o, rts_n_oe, irq, brk_req, txd_w;
  logic [7:0] d, b;
  logic p, s;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  int brk_cnt = 0;
  int n;
  // pull-up holds the line while the port floats
  assign txd_w = txd_oe ? txd_o : 1'b1;
  always #10 core_clk = ~core_clk;
  uwb_uart u_dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rxd_i(rxd), .cts_n_i(cts_n), .txd_o(txd_o),
    .txd_oe(txd_oe), .rts_n_o(rts_n_o), .rts_n_oe(rts_n_oe), .irq(irq),
    .break_reset_req(brk_req));
  uwb_host_model u_host (.core_clk(core_clk), .nrst(nrst), .txd(txd_w),
    .rxd(rxd), .cts_n(cts_n));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (brk_req === 1'b1)
      brk_cnt++;
    if (cyc == 70000)
    begin
      failures++;
      complete_run();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // n ends as the number of clocks the next low stretch on txd lasts
  task automatic low_len();
    n = 0;
    while (txd_o !== 1'b0 && n < 1000)
    begin
      @(negedge core_clk);
      n++;
    end
    n = 0;
    while (txd_o === 1'b0 && n < 5000)
    begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  initial
  begin
    repeat (12) @(posedge core_clk);
    `UWB_CHK({txd_oe, rts_n_oe}, 2'b00, "port driven in reset")
    nrst <= 1'b1;
    rd(8'h04);
    `UWB_CHK({txd_oe, rts_n_oe}, 2'b11, "port floats")
    `UWB_CHK(v, 32'h000001d8, "divisor reset")
    rd(8'h40);
    `UWB_CHK(v, 32'h0, "unmapped read")
    wr(8'h0c, 32'h0);
    low_len();
    // start plus eight zero bits at 115200
    `UWB_CHK(n inside {[3903:3907]}, 1'b1, "bit time")
    repeat (900) @(negedge core_clk);
    // start plus eight zero bits at 2764800
    wr(8'h04, 32'h2c3d);
    wr(8'h0c, 32'h0);
    low_len();
    `UWB_CHK(n inside {[161:164]}, 1'b1, "fast bit time")
    repeat (40) @(negedge core_clk);
    $display("test rate done");
    wr(8'h04, 32'h2800);
    for (int m = 0; m < 3; m++)
    begin
      b = 8'h5a + 8'(m);
      wr(8'h00, (m == 1) ? 32'h5 : 32'(m));
      wr(8'h0c, {24'h0, b});
      u_host.take(m != 0, d, p, s);
      `UWB_CHK(d, b, "tx data")
      `UWB_CHK(s, 1'b1, "tx stop")
      if (m != 0)
        `UWB_CHK(p, (m == 1) ? ~^b : ^b, "tx parity")
      u_host.send(~b, 2'(m), m == 1, 1'b0, 1'b0);
      rd(8'h10);
      `UWB_CHK(v, {24'h0, ~b}, "rx data")
      rd(8'h18);
      `UWB_CHK(v, 32'h3, "done flags")
      wr(8'h18, 32'h1f);
    end
    wr(8'h00, 32'h3);
    u_host.send(8'h33, 2'b10, 1'b0, 1'b1, 1'b0);
    rd(8'h18);
    `UWB_CHK(v, 32'h5, "parity error")
    wr(8'h18, 32'h1f);
    u_host.send(8'h33, 2'b10, 1'b0, 1'b0, 1'b1);
    rd(8'h18);
    `UWB_CHK(v, 32'h9, "frame error")
    `UWB_CHK(irq, 1'b0, "irq masked")
    wr(8'h1c, 32'h8);
    `UWB_CHK(irq, 1'b1, "irq raised")
    wr(8'h18, 32'h1f);
    `UWB_CHK(irq, 1'b0, "irq cleared")
    rd(8'h10);
    $display("test frames done");
    u_host.cts_q <= 1'b1;
    wr(8'h00, 32'h8);
    wr(8'h0c, 32'h81);
    repeat (100) @(negedge core_clk);
    `UWB_CHK(txd_o, 1'b1, "cts ignored")
    `UWB_CHK(rts_n_o, 1'b0, "rts not ready")
    rd(8'h14);
    `UWB_CHK(v, 32'h31, "status held by cts")
    u_host.cts_q <= 1'b0;
    u_host.take(1'b0, d, p, s);
    `UWB_CHK(d, 8'h81, "tx after cts")
    u_host.send(8'h42, 2'b00, 1'b0, 1'b0, 1'b0);
    `UWB_CHK(rts_n_o, 1'b1, "rts not busy")
    rd(8'h10);
    `UWB_CHK(v, 32'h42, "rx with flow")
    repeat (3) @(negedge core_clk);
    `UWB_CHK(rts_n_o, 1'b0, "rts not freed")
    $display("test flow done");
    wr(8'h00, 32'h10);
    repeat (60) @(negedge core_clk);
    `UWB_CHK(txd_o, 1'b0, "break not sent")
    rd(8'h14);
    `UWB_CHK(v[3], 1'b1, "break status")
    wr(8'h00, 32'h0);
    repeat (60) @(negedge core_clk);
    `UWB_CHK(txd_o, 1'b1, "break not ended")
    // 999 acts as off, so no reset after more than 1000 us low
    wr(8'h08, 32'h3e7);
    u_host.bits(1'b0, 50100);
    `UWB_CHK(brk_cnt, 0, "timeout not off")
    wr(8'h08, 32'h3e8);
    repeat (400) @(negedge core_clk);
    `UWB_CHK(brk_cnt, 1, "break reset count")
    u_host.bits(1'b1, 40);
    rd(8'h18);
    `UWB_CHK(v[4], 1'b1, "break irq flag")
    $display("test break done");
    complete_run();
  end
endmodule
